// ===== hdl/move_arith_datapath.sv
// Operation
// - Move bytes or words among registers, memory, immediates.
// - Short absolute form is byte only.
// - Push predecrements stack pointer then stores word.
// - Pop loads word then postincrements stack pointer.
// - Add and subtract registers; add also immediate.
// - No immediate subtract.
// - Word add and subtract register operands only.
// - Carry add and borrow subtract on bytes.
// - Increment or decrement byte register by one.
// - Word small add or subtract by one or two.
// - Decimal adjust byte using condition flags.
// - Unsigned eight by eight multiply, sixteen bit product.
// - Unsigned sixteen by eight divide, quotient and remainder.
// - Compare sets flags only, no store.
// - Word compare register operands only.
// - Negate byte as zero minus register.
// - Short absolute address upper byte all ones.
// - Odd word address clears bit zero.
// - Post increment and predecrement step one or two.
`timescale 1ns/1ps
`default_nettype none
`include "datapath_cfg.svh"
module move_arith_datapath
	import datapath_pkg::*;
#(
	parameter int NUM_REGS = 8
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	// Instruction from sequencer
	input  wire logic        start_i,
	input  wire op_t         op_i,
	input  wire amode_t      amode_i,
	input  wire logic        word_i,
	input  wire logic        use_imm_i,
	input  wire logic [2:0]  dst_i,
	input  wire logic [2:0]  src_i,
	input  wire logic [15:0] imm_i,
	input  wire logic [15:0] disp_i,
	// Memory bus
	input  wire logic        mem_ack_i,
	input  wire logic [15:0] mem_rdata_i,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic             mem_word_o,
	output logic      [15:0] mem_addr_o,
	output logic      [15:0] mem_wdata_o,
	// Status
	output logic             busy_o,
	output logic             done_o,
	output logic             illegal_o,
	output logic      [3:0]  flags_o
);
	if (NUM_REGS != 8) begin : g_bad_num_regs
		$error("NUM_REGS must be 8");
	end

	typedef struct packed {
		state_t              st;
		logic [7:0][15:0]    regs;
		logic [3:0]          flags;
		logic                req;
		logic                we;
		logic                wsz;
		logic [15:0]         addr;
		logic [15:0]         wdata;
		logic [2:0]          rdst;
		logic                done;
		logic                ill;
	} dp_state_t;

	dp_state_t s_r;
	dp_state_t s_nxt;

	logic [15:0] a_op;
	logic [15:0] b_op;
	logic [15:0] alu_res;
	logic [3:0]  alu_flags;
	logic        alu_wr;
	logic [15:0] base;
	logic [15:0] step;
	logic [15:0] ea;
	logic        bad;
	logic        is_load;

	assign a_op = s_r.regs[dst_i];
	assign b_op = use_imm_i ? imm_i : s_r.regs[src_i];

	arith_unit u_alu (
		.word_i  (word_i),
		.op_i    (op_i),
		.a_i     (a_op),
		.b_i     (b_op),
		.flags_i (s_r.flags),
		.res_o   (alu_res),
		.flags_o (alu_flags),
		.write_o (alu_wr)
	);

	// Illegal combinations are refused rather than executed so a bad decode cannot corrupt state.
	always_comb begin
		bad = 1'b0;
		case (op_i)
			OP_MOVE_LOAD, OP_MOVE_STORE: begin
				if (amode_i == AM_ABS8 && word_i) bad = 1'b1;
				if ((amode_i == AM_POST_INC || amode_i == AM_PRE_DEC) && !word_i
				    && src_i == `SP_INDEX) bad = 1'b1;
			end
			OP_SUB: bad = use_imm_i;
			OP_ADD: bad = use_imm_i && word_i;
			OP_CMP: bad = use_imm_i && word_i;
			OP_ADD_SMALL, OP_SUB_SMALL: bad = (imm_i != `STEP_BYTE) && (imm_i != `STEP_WORD);
			default: bad = 1'b0;
		endcase
	end

	always_comb begin
		base = s_r.regs[src_i];
		step = word_i ? `STEP_WORD : `STEP_BYTE;
		is_load = (op_i == OP_MOVE_LOAD);
		case (amode_i)
			AM_DISP:     ea = base + disp_i;
			AM_ABS16:    ea = disp_i;
			AM_ABS8:     ea = {`SHORT_ABS_PAGE, disp_i[7:0]};
			AM_PRE_DEC:  ea = base - step;
			default:     ea = base;
		endcase
		if (op_i == OP_PUSH) ea = s_r.regs[`SP_INDEX] - `STEP_WORD;
		if (op_i == OP_POP) ea = s_r.regs[`SP_INDEX];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (start_i) begin
					s_nxt.ill = bad;
					if (bad) begin
						s_nxt.done = 1'b1;
					end else begin
						case (op_i)
							OP_MOVE_REG, OP_MOVE_IMM: begin
								if (word_i) s_nxt.regs[dst_i] = b_op;
								else s_nxt.regs[dst_i][7:0] = b_op[7:0];
								s_nxt.done = 1'b1;
							end
							OP_MOVE_LOAD, OP_MOVE_STORE, OP_PUSH, OP_POP: begin
								s_nxt.wsz = word_i || op_i == OP_PUSH || op_i == OP_POP;
								s_nxt.addr = s_nxt.wsz ? {ea[15:1], 1'b0} : ea;
								s_nxt.we = (op_i == OP_MOVE_STORE || op_i == OP_PUSH);
								s_nxt.wdata = (op_i == OP_PUSH) ? s_r.regs[src_i] : a_op;
								s_nxt.rdst = (is_load || op_i == OP_POP) ? dst_i : src_i;
								s_nxt.req = 1'b1;
								s_nxt.st = ST_MEM;
								if (op_i == OP_PUSH) s_nxt.regs[`SP_INDEX] = ea;
								if (op_i == OP_POP)
									s_nxt.regs[`SP_INDEX] = ea + `STEP_WORD;
								if (amode_i == AM_PRE_DEC && op_i == OP_MOVE_STORE)
									s_nxt.regs[src_i] = ea;
								if (amode_i == AM_POST_INC && is_load)
									s_nxt.regs[src_i] = base + step;
							end
							OP_ADD_SMALL: begin
								s_nxt.regs[dst_i] = a_op + imm_i;
								s_nxt.done = 1'b1;
							end
							OP_SUB_SMALL: begin
								s_nxt.regs[dst_i] = a_op - imm_i;
								s_nxt.done = 1'b1;
							end
							OP_NOP: s_nxt.done = 1'b1;
							default: begin
								if (alu_wr) s_nxt.regs[dst_i] = alu_res;
								s_nxt.flags = alu_flags;
								s_nxt.done = 1'b1;
							end
						endcase
					end
				end
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					s_nxt.req = 1'b0;
					s_nxt.st = ST_IDLE;
					s_nxt.done = 1'b1;
					if (!s_r.we) begin
						if (s_r.wsz) s_nxt.regs[s_r.rdst] = mem_rdata_i;
						else s_nxt.regs[s_r.rdst][7:0] = mem_rdata_i[7:0];
					end
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign mem_req_o   = s_r.req;
	assign mem_we_o    = s_r.we;
	assign mem_word_o  = s_r.wsz;
	assign mem_addr_o  = s_r.addr;
	assign mem_wdata_o = s_r.wdata;
	// The request flop is set exactly while the memory state is held, so it doubles as busy.
	assign busy_o      = s_r.req;
	assign done_o      = s_r.done;
	assign illegal_o   = s_r.ill;
	assign flags_o     = s_r.flags;
endmodule : move_arith_datapath
`default_nettype wire

// ===== hdl/datapath_cfg.svh
`ifndef DATAPATH_CFG_SVH
`define DATAPATH_CFG_SVH
`define SHORT_ABS_PAGE    8'hFF
`define SP_INDEX          3'h7
`define STEP_BYTE         16'h0001
`define STEP_WORD         16'h0002
`define REG_RESET         16'h0000
`define FLAG_RESET        4'h0
`define FLAG_N            3
`define FLAG_Z            2
`define FLAG_V            1
`define FLAG_C            0
`endif

// ===== hdl/datapath_pkg.sv
package datapath_pkg;
	typedef enum logic [4:0] {
		OP_NOP,
		OP_MOVE_REG,
		OP_MOVE_IMM,
		OP_MOVE_LOAD,
		OP_MOVE_STORE,
		OP_PUSH,
		OP_POP,
		OP_ADD,
		OP_SUB,
		OP_ADD_CARRY,
		OP_SUB_BORROW,
		OP_INC,
		OP_DEC,
		OP_ADD_SMALL,
		OP_SUB_SMALL,
		OP_DEC_ADJ_ADD,
		OP_DEC_ADJ_SUB,
		OP_MUL,
		OP_DIV,
		OP_CMP,
		OP_NEG
	} op_t;
	typedef enum logic [2:0] {
		AM_REG_IND,
		AM_DISP,
		AM_ABS16,
		AM_ABS8,
		AM_POST_INC,
		AM_PRE_DEC
	} amode_t;
	typedef enum {
		ST_IDLE,
		ST_MEM
	} state_t;
endpackage : datapath_pkg

// ===== hdl/arith_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "datapath_cfg.svh"
module arith_unit
	import datapath_pkg::*;
(
	// Operation and operands
	input  wire logic        word_i,
	input  wire op_t         op_i,
	input  wire logic [15:0] a_i,
	input  wire logic [15:0] b_i,
	input  wire logic [3:0]  flags_i,
	// Result
	output logic      [15:0] res_o,
	output logic      [3:0]  flags_o,
	output logic             write_o
);
	logic [16:0] sum;
	logic [15:0] mul;
	logic [7:0]  quo;
	logic [7:0]  rem;
	logic [7:0]  adj;
	logic        cin;
	logic        sub;
	logic        nz;
	always_comb begin
		sum     = 17'h0_0000;
		mul     = {8'h00, a_i[7:0]} * {8'h00, b_i[7:0]};
		quo     = 8'h00;
		rem     = 8'h00;
		adj     = 8'h00;
		cin     = flags_i[`FLAG_C];
		sub     = 1'b0;
		nz      = 1'b1;
		res_o   = a_i;
		flags_o = flags_i;
		write_o = 1'b1;
		case (op_i)
			OP_ADD, OP_SUB, OP_CMP: begin
				sub = (op_i != OP_ADD);
				sum = sub ? {1'b0, a_i} - {1'b0, b_i} : {1'b0, a_i} + {1'b0, b_i};
				// Byte forms take their carry from the low bytes alone, whatever the high bytes hold.
				if (!word_i) begin
					sum = sub ? {9'h000, a_i[7:0]} - {9'h000, b_i[7:0]}
					          : {9'h000, a_i[7:0]} + {9'h000, b_i[7:0]};
				end
				write_o = (op_i != OP_CMP);
			end
			OP_ADD_CARRY: sum = {9'h000, a_i[7:0]} + {9'h000, b_i[7:0]} + {16'h0000, cin};
			OP_SUB_BORROW: begin
				sub = 1'b1;
				sum = {9'h000, a_i[7:0]} - {9'h000, b_i[7:0]} - {16'h0000, cin};
			end
			OP_INC: sum = {9'h000, a_i[7:0]} + 17'h0_0001;
			OP_DEC: begin
				sub = 1'b1;
				sum = {9'h000, a_i[7:0]} - 17'h0_0001;
			end
			OP_NEG: begin
				sub = 1'b1;
				sum = 17'h0_0000 - {9'h000, a_i[7:0]};
			end
			OP_DEC_ADJ_ADD: begin
				adj = 8'h00;
				if (flags_i[`FLAG_C] || a_i[7:0] > 8'h99) adj = 8'h60;
				if (a_i[3:0] > 4'h9) adj = adj | 8'h06;
				sum = {9'h000, a_i[7:0]} + {9'h000, adj};
				sum[8] = adj[6];
			end
			OP_DEC_ADJ_SUB: begin
				adj = flags_i[`FLAG_C] ? 8'hA0 : 8'h00;
				if (a_i[3:0] > 4'h9) adj = adj | 8'h0A;
				sum = {9'h000, a_i[7:0]} + {9'h000, adj};
				sum[8] = flags_i[`FLAG_C];
			end
			default: ;
		endcase
		if (word_i && (op_i == OP_ADD || op_i == OP_SUB || op_i == OP_CMP)) begin
			res_o = sum[15:0];
			flags_o[`FLAG_N] = sum[15];
			flags_o[`FLAG_Z] = (sum[15:0] == 16'h0000);
			flags_o[`FLAG_C] = sum[16];
			flags_o[`FLAG_V] = sub ? (a_i[15] ^ b_i[15]) & (a_i[15] ^ sum[15])
			                       : ~(a_i[15] ^ b_i[15]) & (a_i[15] ^ sum[15]);
		end else begin
			nz = 1'b1;
			case (op_i)
				OP_MUL: begin
					res_o = mul;
					nz = 1'b0;
				end
				OP_DIV: begin
					if (b_i[7:0] != 8'h00) begin
						quo = 8'(a_i / {8'h00, b_i[7:0]});
						rem = 8'(a_i % {8'h00, b_i[7:0]});
					end
					res_o = {rem, quo};
					nz = 1'b0;
					flags_o[`FLAG_N] = b_i[7];
					flags_o[`FLAG_Z] = (b_i[7:0] == 8'h00);
				end
				OP_ADD, OP_SUB, OP_CMP, OP_ADD_CARRY, OP_SUB_BORROW, OP_INC, OP_DEC,
				OP_NEG, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB: begin
					res_o = {a_i[15:8], sum[7:0]};
					flags_o[`FLAG_N] = sum[7];
					flags_o[`FLAG_Z] = (sum[7:0] == 8'h00);
					if (op_i != OP_INC && op_i != OP_DEC) flags_o[`FLAG_C] = sum[8];
					if (op_i == OP_NEG) flags_o[`FLAG_V] = (a_i[7:0] == 8'h80);
					else if (op_i != OP_DEC_ADJ_ADD && op_i != OP_DEC_ADJ_SUB)
						flags_o[`FLAG_V] = sub ? (a_i[7] ^ b_i[7]) & (a_i[7] ^ sum[7])
						                       : ~(a_i[7] ^ b_i[7]) & (a_i[7] ^ sum[7]);
					if (op_i == OP_INC) flags_o[`FLAG_V] = (a_i[7:0] == 8'h7F);
					if (op_i == OP_DEC) flags_o[`FLAG_V] = (a_i[7:0] == 8'h80);
				end
				default: write_o = 1'b0;
			endcase
			if (!nz) flags_o[`FLAG_C] = flags_i[`FLAG_C];
		end
	end
endmodule : arith_unit
`default_nettype wire

// ===== testbench/datapath_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module datapath_monitor
	import datapath_pkg::*;
#(
	parameter int NUM_REGS = 8
) (
	// Instruction side
	input wire logic        mclk_i,
	input wire logic        arst_n_i,
	input wire logic        start_i,
	input wire op_t         op_i,
	input wire amode_t      amode_i,
	input wire logic        word_i,
	input wire logic        use_imm_i,
	input wire logic [15:0] imm_i,
	input wire logic [15:0] disp_i,
	// Memory and status
	input wire logic        mem_ack_i,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic        mem_word_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        illegal_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	logic [15:0] page_addr;
	assign page_addr = {8'hFF, disp_i[7:0]};
	sequence s_take(c);
		start_i && !busy_o && c;
	endsequence
	sequence s_refused;
		done_o && illegal_o && !mem_req_o;
	endsequence
	property p_req_hold;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
	endproperty
	property p_ack_fin;
		mem_req_o && mem_ack_i |=> done_o && !mem_req_o;
	endproperty
	property p_page;
		s_take(op_i == OP_MOVE_STORE && amode_i == AM_ABS8 && !word_i)
			|=> mem_req_o && !mem_word_o && mem_addr_o == $past(page_addr);
	endproperty
	property p_even;
		mem_req_o && mem_word_o |-> !mem_addr_o[0];
	endproperty
	property p_no_imm_sub;
		s_take(op_i == OP_SUB && use_imm_i) |=> s_refused;
	endproperty
	property p_word_imm;
		s_take(op_i inside {OP_ADD, OP_CMP} && word_i && use_imm_i) |=> s_refused;
	endproperty
	property p_small;
		s_take(op_i == OP_ADD_SMALL && !(imm_i inside {16'h0001, 16'h0002})) |=> s_refused;
	endproperty
	property p_push;
		s_take(op_i == OP_PUSH) |=> mem_req_o && mem_we_o && mem_word_o;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	a_ack_fin: assert property (p_ack_fin) else $error("no finish");
	a_page: assert property (p_page) else $error("bad page");
	a_even: assert property (p_even) else $error("odd word");
	a_no_imm_sub: assert property (p_no_imm_sub) else $error("sub imm");
	a_word_imm: assert property (p_word_imm) else $error("word imm");
	a_small: assert property (p_small) else $error("small imm");
	a_push: assert property (p_push) else $error("push");
endmodule : datapath_monitor
bind move_arith_datapath datapath_monitor #(.NUM_REGS(NUM_REGS)) i_datapath_monitor (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(start_i), .op_i(op_i),
	.amode_i(amode_i), .word_i(word_i), .use_imm_i(use_imm_i), .imm_i(imm_i),
	.disp_i(disp_i), .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.mem_word_o(mem_word_o), .mem_addr_o(mem_addr_o), .busy_o(busy_o),
	.done_o(done_o), .illegal_o(illegal_o));
`default_nettype wire

// ===== testbench/stack_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module stack_memory_model (
	// Bus from the datapath
	input  wire logic        mclk_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output var logic         ack_o,
	output var logic  [15:0] rdata_o
);
	logic [15:0] mem [logic [15:0]];
	int          cnt;
	// Read data flips when idle and after each answer, so a late sample never sees a held value.
	initial begin
		ack_o = 1'b0;
		rdata_o = 16'h0000;
		cnt = 0;
		forever begin
			@(posedge mclk_i);
			#1;
			if (ack_o || !req_i) begin
				ack_o = 1'b0;
				rdata_o = ~rdata_o;
				cnt = $urandom_range(2, 0);
			end else if (cnt > 0) begin
				cnt--;
			end else begin
				ack_o = 1'b1;
				if (we_i) mem[addr_i] = wdata_i;
				else rdata_o = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
			end
		end
	end
endmodule : stack_memory_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import datapath_pkg::*;
;
	logic        mclk_i, arst_n_i, ce_i, start_i, word_i, use_imm_i, mem_ack_i, cap_v;
	logic        mem_req_o, mem_we_o, mem_word_o, busy_o, done_o, illegal_o;
	op_t         op_i;
	amode_t      amode_i;
	logic [2:0]  dst_i, src_i;
	logic [3:0]  flags_o;
	logic [7:0]  d8, q8, r8;
	logic [15:0] imm_i, disp_i, mem_rdata_i, mem_addr_o, mem_wdata_o, cap_a, cap_d;
	logic [15:0] rm [8];
	logic [31:0] v;
	int          bad_count, samples_checked;
	move_arith_datapath #(.NUM_REGS(8)) i_move_arith_datapath (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .ce_i(ce_i), .start_i(start_i), .op_i(op_i), .amode_i(amode_i),
		.word_i(word_i), .use_imm_i(use_imm_i), .dst_i(dst_i), .src_i(src_i), .imm_i(imm_i),
		.disp_i(disp_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_word_o(mem_word_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .busy_o(busy_o),
		.done_o(done_o), .illegal_o(illegal_o), .flags_o(flags_o));
	stack_memory_model i_stack_memory_model (.mclk_i(mclk_i), .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	function automatic logic [15:0] bx(input logic [15:0] o, input logic [7:0] b);
		return {o[15:8], b};
	endfunction : bx
	task automatic x(input op_t o, input amode_t m, input logic w, input logic u,
			input logic [2:0] d, input logic [2:0] s, input logic [15:0] im,
			input logic [15:0] dp, input logic il);
		op_i = o;
		amode_i = m;
		word_i = w;
		use_imm_i = u;
		dst_i = d;
		src_i = s;
		imm_i = im;
		disp_i = dp;
		start_i = 1'b1;
		cap_v = 1'b0;
		@(posedge mclk_i);
		#1;
		start_i = 1'b0;
		for (int i = 0; i < 20 && done_o !== 1'b1; i++) begin
			if (mem_req_o === 1'b1) begin
				cap_v = 1'b1;
				cap_a = mem_addr_o;
				cap_d = mem_wdata_o;
			end
			@(posedge mclk_i);
			#1;
		end
		if (done_o !== 1'b1) begin
			bad_count++;
			end_of_test();
		end else begin
			chk("illegal", {15'h0000, il}, {15'h0000, illegal_o});
		end
	endtask : x
	task automatic a(input op_t o, input logic w, input logic u, input logic [2:0] d,
			input logic [2:0] s, input logic [15:0] im, input logic il);
		x(o, AM_REG_IND, w, u, d, s, im, 16'h0000, il);
	endtask : a
	task automatic ld(input logic [2:0] r, input logic [15:0] val);
		a(OP_MOVE_IMM, 1'b1, 1'b1, r, 3'h0, val, 1'b0);
		rm[r] = val;
	endtask : ld
	// Register contents only show through a word store to a fixed spot.
	task automatic show(input logic [2:0] r);
		x(OP_MOVE_STORE, AM_ABS16, 1'b1, 1'b0, r, 3'h0, 16'h0000, 16'h0100, 1'b0);
		chk("reg", rm[r], cap_d);
	endtask : show
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		{arst_n_i, start_i, word_i, use_imm_i, dst_i, src_i, imm_i, disp_i} = '0;
		ce_i = 1'b1;
		op_i = OP_NOP;
		amode_i = AM_REG_IND;
		bad_count = 0;
		samples_checked = 0;
		v = $urandom(32'h4bf6_294a);
		repeat (10) @(posedge mclk_i);
		#1;
		arst_n_i = 1'b1;
		v = $urandom;
		ld(1, v[15:0]);
		ld(2, v[31:16]);
		a(OP_ADD, 0, 0, 1, 2, 16'h0000, 0);
		rm[1] = bx(rm[1], rm[1][7:0] + rm[2][7:0]);
		show(1);
		a(OP_SUB, 1, 0, 1, 2, 16'h0000, 0);
		rm[1] = rm[1] - rm[2];
		show(1);
		a(OP_ADD, 0, 1, 2, 0, 16'h0033, 0);
		rm[2] = bx(rm[2], rm[2][7:0] + 8'h33);
		show(2);
		a(OP_MUL, 0, 0, 1, 2, 16'h0000, 0);
		rm[1] = rm[1][7:0] * rm[2][7:0];
		show(1);
		v = $urandom;
		d8 = v[7:0] | 8'h01;
		q8 = v[15:8];
		r8 = v[23:16] % d8;
		ld(2, {v[31:24], d8});
		ld(1, d8 * q8 + r8);
		a(OP_DIV, 0, 0, 1, 2, 16'h0000, 0);
		rm[1] = {r8, q8};
		show(1);
		$display("test arithmetic done");
		ld(3, 16'h0105);
		ld(4, 16'h0007);
		a(OP_CMP, 0, 0, 3, 4, 16'h0000, 0);
		chk("flags", 16'h0009, {12'h000, flags_o});
		a(OP_ADD_CARRY, 0, 0, 3, 4, 16'h0000, 0);
		rm[3] = bx(rm[3], 8'h0D);
		show(3);
		a(OP_CMP, 0, 1, 3, 0, 16'h000D, 0);
		chk("flags", 16'h0004, {12'h000, flags_o});
		a(OP_SUB_BORROW, 0, 0, 3, 4, 16'h0000, 0);
		rm[3] = bx(rm[3], 8'h06);
		show(3);
		// An increment offered while the enable is low must leave no trace.
		ce_i = 1'b0;
		op_i = OP_INC;
		dst_i = 3'h3;
		start_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		#1;
		start_i = 1'b0;
		ce_i = 1'b1;
		@(posedge mclk_i);
		#1;
		show(3);
		v = $urandom;
		ld(5, v[15:0]);
		a(OP_INC, 0, 0, 5, 0, 16'h0000, 0);
		rm[5] = bx(rm[5], rm[5][7:0] + 8'h01);
		a(OP_DEC, 0, 0, 5, 0, 16'h0000, 0);
		a(OP_DEC, 0, 0, 5, 0, 16'h0000, 0);
		rm[5] = bx(rm[5], rm[5][7:0] - 8'h02);
		show(5);
		a(OP_NEG, 0, 0, 5, 0, 16'h0000, 0);
		rm[5] = bx(rm[5], 8'h00 - rm[5][7:0]);
		a(OP_ADD_SMALL, 1, 1, 5, 0, 16'h0002, 0);
		a(OP_SUB_SMALL, 1, 1, 5, 0, 16'h0001, 0);
		rm[5] = rm[5] + 16'h0001;
		show(5);
		ld(6, 16'h0009);
		a(OP_ADD, 0, 1, 6, 0, 16'h0001, 0);
		a(OP_DEC_ADJ_ADD, 0, 0, 6, 0, 16'h0000, 0);
		rm[6] = 16'h0010;
		show(6);
		ld(6, 16'h0018);
		a(OP_SUB, 0, 0, 6, 4, 16'h0000, 0);
		a(OP_DEC_ADJ_SUB, 0, 0, 6, 0, 16'h0000, 0);
		rm[6] = 16'h0011;
		show(6);
		a(OP_MOVE_REG, 0, 0, 6, 3, 16'h0000, 0);
		rm[6] = bx(rm[6], rm[3][7:0]);
		show(6);
		$display("test flags done");
		a(OP_SUB, 0, 1, 1, 0, 16'h0001, 1);
		a(OP_ADD, 1, 1, 1, 0, 16'h0001, 1);
		a(OP_CMP, 1, 1, 1, 0, 16'h0001, 1);
		a(OP_ADD_SMALL, 1, 1, 1, 0, 16'h0003, 1);
		x(OP_MOVE_STORE, AM_ABS8, 1, 0, 1, 0, 16'h0000, 16'h0034, 1);
		chk("req", 16'h0000, {15'h0000, cap_v});
		x(OP_MOVE_LOAD, AM_POST_INC, 0, 0, 1, 7, 16'h0000, 16'h0000, 1);
		show(1);
		$display("test refusals done");
		x(OP_MOVE_STORE, AM_ABS8, 0, 0, 2, 0, 16'h0000, 16'h0034, 0);
		chk("addr", 16'hFF34, cap_a);
		x(OP_MOVE_STORE, AM_ABS16, 1, 0, 2, 0, 16'h0000, 16'h1235, 0);
		chk("addr", 16'h1234, cap_a);
		ld(7, 16'h2000);
		x(OP_PUSH, AM_PRE_DEC, 1, 0, 0, 3, 16'h0000, 16'h0000, 0);
		chk("addr", 16'h1FFE, cap_a);
		chk("data", rm[3], cap_d);
		rm[7] = 16'h1FFE;
		show(7);
		x(OP_POP, AM_POST_INC, 1, 0, 4, 0, 16'h0000, 16'h0000, 0);
		chk("addr", 16'h1FFE, cap_a);
		rm[4] = rm[3];
		rm[7] = 16'h2000;
		show(4);
		show(7);
		x(OP_MOVE_LOAD, AM_DISP, 1, 0, 6, 7, 16'h0000, 16'hFFFE, 0);
		chk("addr", 16'h1FFE, cap_a);
		rm[6] = rm[3];
		show(6);
		ld(5, 16'h3000);
		x(OP_MOVE_LOAD, AM_POST_INC, 0, 0, 6, 5, 16'h0000, 16'h0000, 0);
		chk("addr", 16'h3000, cap_a);
		rm[6] = bx(rm[6], 8'h00);
		show(6);
		x(OP_MOVE_STORE, AM_PRE_DEC, 0, 0, 2, 5, 16'h0000, 16'h0000, 0);
		chk("addr", 16'h3000, cap_a);
		show(5);
		$display("test memory done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
